/* hdl/cfsp_top.sv */
// cube face select, seamless cube wrap control and texture parameter check
// assumes: APB master on pclk, fragment source and sink with valid/ready
//
// Local design decisions: register access over APB and the register addresses.
`include "cfsp_cfg.svh"
`default_nettype none
module cfsp_top (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire cfsp_pkg::cfsp_apb_req_t apb_req,
	output var  cfsp_pkg::cfsp_apb_rsp_t apb_rsp,
	input  wire cfsp_pkg::cfsp_dir_t     frag_dir,
	input  wire logic                   frag_valid,
	output logic                        frag_ready,
	output var  cfsp_pkg::cfsp_coord_t   cube_out,
	output logic                        cube_valid,
	input  wire logic                   cube_ready,
	input  wire cfsp_pkg::cfsp_corner_t  corner_in,
	output logic                        corner_valid,
	output logic [31:0]                 corner_texel,
	output var  cfsp_pkg::cfsp_param_t   param_out
);
	import cfsp_pkg::*;

	cfsp_state_t st_reg;
	cfsp_state_t st_next;
	logic [31:0] lane_mean;

	// four byte lanes, one mean cell each
	for (genvar g = 0; g < 4; g++) begin : g_lane
		cfsp_lane_mean i_cfsp_lane_mean (
			.a    (corner_in.a[g*8 +: 8]),
			.b    (corner_in.b[g*8 +: 8]),
			.c    (corner_in.c[g*8 +: 8]),
			.mean (lane_mean[g*8 +: 8])
		);
	end

	// tie rule depends only on the three components
	function automatic cfsp_sel_t cfsp_select(input cfsp_dir_t d);
		logic signed [16:0] x;
		logic signed [16:0] y;
		logic signed [16:0] z;
		logic [16:0]        ax;
		logic [16:0]        ay;
		logic [16:0]        az;
		cfsp_sel_t          r;
		// 17 bits so that the most negative input has a magnitude
		x = {d.x[15], d.x};
		y = {d.y[15], d.y};
		z = {d.z[15], d.z};
		ax = x[16] ? 17'(-x) : 17'(x);
		ay = y[16] ? 17'(-y) : 17'(y);
		az = z[16] ? 17'(-z) : 17'(z);
		if (az >= ay && az >= ax) begin
			r.ama  = az;
			r.face = z[16] ? CFSP_NZ : CFSP_PZ;
			r.sc   = z[16] ? -x : x;
			r.tc   = -y;
		end else if (ay >= ax) begin
			r.ama  = ay;
			r.face = y[16] ? CFSP_NY : CFSP_PY;
			r.sc   = x;
			r.tc   = y[16] ? -z : z;
		end else begin
			r.ama  = ax;
			r.face = x[16] ? CFSP_NX : CFSP_PX;
			r.sc   = x[16] ? z : -z;
			r.tc   = -y;
		end
		return r;
	endfunction

	// neighbours across the s high, s low, t high and t low edges
	function automatic logic [11:0] cfsp_nbr(input cfsp_face_t f);
		case (f)
			CFSP_PX: return {CFSP_NZ, CFSP_PZ, CFSP_NY, CFSP_PY};
			CFSP_NX: return {CFSP_PZ, CFSP_NZ, CFSP_NY, CFSP_PY};
			CFSP_PY: return {CFSP_PX, CFSP_NX, CFSP_PZ, CFSP_NZ};
			CFSP_NY: return {CFSP_PX, CFSP_NX, CFSP_NZ, CFSP_PZ};
			CFSP_PZ: return {CFSP_PX, CFSP_NX, CFSP_NY, CFSP_PY};
			default: return {CFSP_NX, CFSP_PX, CFSP_NY, CFSP_PY};
		endcase
	endfunction

	// one restoring step: {quotient bit, new remainder}
	function automatic logic [18:0] cfsp_step(input logic [17:0] rem, input logic [17:0] den);
		logic [18:0] sh;
		sh = {rem, 1'b0};
		if (sh >= {1'b0, den}) begin
			return {1'b1, 18'(sh - {1'b0, den})};
		end else begin
			return {1'b0, sh[17:0]};
		end
	endfunction

	function automatic logic wrap_is_rep(input logic [2:0] w);
		return (w == CFSP_REPEAT_WRAP) || (w == CFSP_MIRROR_WRAP);
	endfunction

	always_comb begin
		cfsp_sel_t   sel;
		logic [17:0] num;
		logic [18:0] ns;
		logic [18:0] nt;
		logic        wr;
		logic        rect;
		logic [1:0]  err_set;
		logic [1:0]  err_clr;
		logic [4:0]  lvlm1;
		logic [4:0]  eb;
		sel     = cfsp_select(frag_dir);
		num     = 18'($signed({sel.sc[16], sel.sc}) + $signed({1'b0, sel.ama}));
		ns      = cfsp_step(st_reg.rem_s, st_reg.den);
		nt      = cfsp_step(st_reg.rem_t, st_reg.den);
		wr      = apb_req.psel & apb_req.penable & st_reg.rsp.pready & apb_req.pwrite;
		rect    = st_reg.ctrl[`CFSP_CTRL_RECT];
		err_set = 2'h0;
		err_clr = 2'h0;
		lvlm1   = 5'h00;
		eb      = 5'h00;
		st_next = st_reg;

		// register access: zero wait, read data caught in the setup cycle
		st_next.rsp.pready  = apb_req.psel & ~apb_req.penable;
		st_next.rsp.pslverr = 1'b0;
		if (apb_req.psel && !apb_req.penable) begin
			case (apb_req.paddr)
				`CFSP_OFF_CTRL:   st_next.rsp.prdata = {24'h000000, st_reg.ctrl};
				`CFSP_OFF_LEVELS: st_next.rsp.prdata = {27'h0000000, st_reg.levels};
				`CFSP_OFF_BASE:   st_next.rsp.prdata = {27'h0000000, st_reg.base};
				`CFSP_OFF_MAXLVL: st_next.rsp.prdata = {27'h0000000, st_reg.maxlvl};
				`CFSP_OFF_WRAP:   st_next.rsp.prdata = {23'h000000, st_reg.wrap};
				`CFSP_OFF_MINF:   st_next.rsp.prdata = {29'h00000000, st_reg.minf};
				`CFSP_OFF_ERR:    st_next.rsp.prdata = {30'h00000000, st_reg.err};
				`CFSP_OFF_EFF: begin
					st_next.rsp.prdata = 32'h00000000;
					st_next.rsp.prdata[`CFSP_EFF_BASE]  = st_reg.param.eff_base;
					st_next.rsp.prdata[`CFSP_EFF_MAX]   = st_reg.param.eff_max;
					st_next.rsp.prdata[`CFSP_EFF_DEPTH] = st_reg.param.depth;
				end
				default: begin
					st_next.rsp.prdata  = 32'h00000000;
					st_next.rsp.pslverr = 1'b1;
				end
			endcase
		end

		if (wr) begin
			case (apb_req.paddr)
				`CFSP_OFF_CTRL:   st_next.ctrl = apb_req.pwdata[7:0];
				`CFSP_OFF_LEVELS: st_next.levels = apb_req.pwdata[4:0];
				`CFSP_OFF_MAXLVL: st_next.maxlvl = apb_req.pwdata[4:0];
				`CFSP_OFF_BASE: begin
					if (rect && apb_req.pwdata != 32'h00000000) begin
						err_set[`CFSP_ERR_VALUE] = 1'b1;
					end else begin
						st_next.base = apb_req.pwdata[4:0];
					end
				end
				`CFSP_OFF_WRAP: begin
					if (rect && (wrap_is_rep(apb_req.pwdata[`CFSP_WRAP_S]) ||
							wrap_is_rep(apb_req.pwdata[`CFSP_WRAP_T]) ||
							wrap_is_rep(apb_req.pwdata[`CFSP_WRAP_R]))) begin
						err_set[`CFSP_ERR_ENUM] = 1'b1;
					end else begin
						st_next.wrap = apb_req.pwdata[8:0];
					end
				end
				`CFSP_OFF_MINF: begin
					if (rect && apb_req.pwdata[31:1] != 31'h00000000) begin
						err_set[`CFSP_ERR_ENUM] = 1'b1;
					end else begin
						st_next.minf = apb_req.pwdata[2:0];
					end
				end
				`CFSP_OFF_ERR: err_clr = apb_req.pwdata[1:0];
				default: ;
			endcase
		end
		// an error raised in the cycle it is cleared survives
		st_next.err = (st_reg.err & ~err_clr) | err_set;

		// effective levels and shared sampling state, one set for all faces
		lvlm1 = (st_next.levels == 5'h00) ? 5'h00 : 5'(st_next.levels - 5'h01);
		eb    = st_next.base;
		st_next.param.eff_max = st_next.maxlvl;
		if (st_next.ctrl[`CFSP_CTRL_FIXED]) begin
			eb = (st_next.base > lvlm1) ? lvlm1 : st_next.base;
			if (st_next.maxlvl < eb) begin
				st_next.param.eff_max = eb;
			end else if (st_next.maxlvl > lvlm1) begin
				st_next.param.eff_max = lvlm1;
			end
		end
		st_next.param.eff_base   = eb;
		st_next.param.min_filter = st_next.minf;
		st_next.param.seamless   = st_next.ctrl[`CFSP_CTRL_SEAMLESS];
		if (st_next.ctrl[`CFSP_CTRL_DEPTH_OVR]) begin
			st_next.param.depth = cfsp_depth_t'(st_next.ctrl[`CFSP_CTRL_DEPTH_SEL]);
		end else begin
			st_next.param.depth = st_next.ctrl[`CFSP_CTRL_FWDCOMPAT] ? CFSP_DEPTH_RED : CFSP_DEPTH_LUM;
		end
		if (st_next.ctrl[`CFSP_CTRL_SEAMLESS]) begin
			// filter bit 0 marks linear within a level
			if (st_next.minf[0]) begin
				st_next.param.wrap_s = CFSP_BORDER_CLAMP_WRAP;
				st_next.param.wrap_t = CFSP_BORDER_CLAMP_WRAP;
				st_next.param.wrap_r = CFSP_BORDER_CLAMP_WRAP;
			end else begin
				st_next.param.wrap_s = CFSP_EDGE_CLAMP_WRAP;
				st_next.param.wrap_t = CFSP_EDGE_CLAMP_WRAP;
				st_next.param.wrap_r = CFSP_EDGE_CLAMP_WRAP;
			end
		end else begin
			st_next.param.wrap_s = cfsp_wrap_t'(st_next.wrap[`CFSP_WRAP_S]);
			st_next.param.wrap_t = cfsp_wrap_t'(st_next.wrap[`CFSP_WRAP_T]);
			st_next.param.wrap_r = cfsp_wrap_t'(st_next.wrap[`CFSP_WRAP_R]);
		end

		// per-fragment face select and serial divide, 16 fraction bits
		case (st_reg.fsm)
			CFSP_IDLE: begin
				if (frag_valid && st_reg.in_ready) begin
					st_next.out.face = sel.face;
					{st_next.out.nb_s_hi, st_next.out.nb_s_lo,
						st_next.out.nb_t_hi, st_next.out.nb_t_lo} = cfsp_nbr(sel.face);
					st_next.den = {sel.ama, 1'b0};
					// s = (sc + |ma|) / (2|ma|), integer bit set only at s = 1
					if (num >= {sel.ama, 1'b0}) begin
						st_next.q_s   = 17'h10000;
						st_next.rem_s = 18'(num - {sel.ama, 1'b0});
					end else begin
						st_next.q_s   = 17'h00000;
						st_next.rem_s = num;
					end
					num = 18'($signed({sel.tc[16], sel.tc}) + $signed({1'b0, sel.ama}));
					if (num >= {sel.ama, 1'b0}) begin
						st_next.q_t   = 17'h10000;
						st_next.rem_t = 18'(num - {sel.ama, 1'b0});
					end else begin
						st_next.q_t   = 17'h00000;
						st_next.rem_t = num;
					end
					st_next.cnt = 5'h00;
					st_next.fsm = CFSP_DIV;
				end
			end
			CFSP_DIV: begin
				st_next.rem_s = ns[17:0];
				st_next.rem_t = nt[17:0];
				st_next.q_s   = {st_reg.q_s[16], st_reg.q_s[14:0], ns[18]};
				st_next.q_t   = {st_reg.q_t[16], st_reg.q_t[14:0], nt[18]};
				st_next.cnt   = 5'(st_reg.cnt + 5'h01);
				if (st_reg.cnt == `CFSP_DIV_LAST) begin
					// a zero vector has no face; give the centre-free origin
					st_next.out.s     = (st_reg.den == 18'h00000) ? 17'h00000 : st_next.q_s;
					st_next.out.t     = (st_reg.den == 18'h00000) ? 17'h00000 : st_next.q_t;
					st_next.out_valid = 1'b1;
					st_next.fsm       = CFSP_DONE;
				end
			end
			CFSP_DONE: begin
				if (cube_ready) begin
					st_next.out_valid = 1'b0;
					st_next.fsm       = CFSP_IDLE;
				end
			end
			default: st_next.fsm = CFSP_IDLE;
		endcase
		st_next.in_ready = (st_next.fsm == CFSP_IDLE) & st_next.ctrl[`CFSP_CTRL_CUBE_EN];

		// corner texel: lane means are combinational, caught here so the output is a flop
		st_next.cor_valid = corner_in.valid;
		if (corner_in.valid) begin
			st_next.cor_texel = lane_mean;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg        <= '0;
			st_reg.ctrl   <= `CFSP_RST_CTRL;
			st_reg.levels <= `CFSP_RST_LEVELS;
			st_reg.base   <= `CFSP_RST_BASE;
			st_reg.maxlvl <= `CFSP_RST_MAXLVL;
			st_reg.wrap   <= `CFSP_RST_WRAP;
			st_reg.minf   <= `CFSP_RST_MINF;
			st_reg.fsm    <= CFSP_IDLE;
			st_reg.param.wrap_s     <= CFSP_REPEAT_WRAP;
			st_reg.param.wrap_t     <= CFSP_REPEAT_WRAP;
			st_reg.param.wrap_r     <= CFSP_REPEAT_WRAP;
			st_reg.param.min_filter <= `CFSP_RST_MINF;
		end else begin
			st_reg <= st_next;
		end
	end

	assign apb_rsp      = st_reg.rsp;
	assign frag_ready   = st_reg.in_ready;
	assign cube_out     = st_reg.out;
	assign cube_valid   = st_reg.out_valid;
	assign corner_valid = st_reg.cor_valid;
	assign corner_texel = st_reg.cor_texel;
	assign param_out    = st_reg.param;
endmodule

// one byte lane of the corner texel: floor of the mean of three samples
module cfsp_lane_mean #(
	parameter int LANE_W = 8
) (
	input  wire logic [LANE_W-1:0] a,
	input  wire logic [LANE_W-1:0] b,
	input  wire logic [LANE_W-1:0] c,
	output logic      [LANE_W-1:0] mean
);
	logic [LANE_W+1:0]  sum;
	logic [LANE_W+17:0] prod;
	// x/3 as x*0x5556>>16: no divider, and exact when all three samples agree
	assign sum  = {2'b00, a} + {2'b00, b} + {2'b00, c};
	assign prod = {{16{1'b0}}, sum} * {{(LANE_W+2){1'b0}}, `CFSP_THIRD};
	assign mean = prod[LANE_W+15:16];
endmodule
`default_nettype wire

/* hdl/cfsp_cfg.svh */
// register offsets, field positions, reset values and timing counts
// assumes: included by the top module only
`ifndef CFSP_CFG_SVH
`define CFSP_CFG_SVH
`define CFSP_OFF_CTRL        8'h00
`define CFSP_OFF_LEVELS      8'h04
`define CFSP_OFF_BASE        8'h08
`define CFSP_OFF_MAXLVL      8'h0C
`define CFSP_OFF_WRAP        8'h10
`define CFSP_OFF_MINF        8'h14
`define CFSP_OFF_ERR         8'h18
`define CFSP_OFF_EFF         8'h1C
`define CFSP_CTRL_SEAMLESS   0
`define CFSP_CTRL_FIXED      1
`define CFSP_CTRL_RECT       2
`define CFSP_CTRL_FWDCOMPAT  3
`define CFSP_CTRL_CUBE_EN    4
`define CFSP_CTRL_DEPTH_OVR  5
`define CFSP_CTRL_DEPTH_SEL  7:6
`define CFSP_WRAP_S          2:0
`define CFSP_WRAP_T          5:3
`define CFSP_WRAP_R          8:6
`define CFSP_ERR_ENUM        0
`define CFSP_ERR_VALUE       1
`define CFSP_EFF_BASE        4:0
`define CFSP_EFF_MAX         12:8
`define CFSP_EFF_DEPTH       17:16
`define CFSP_RST_CTRL        8'h00
`define CFSP_RST_LEVELS      5'h01
`define CFSP_RST_BASE        5'h00
`define CFSP_RST_MAXLVL      5'h1F
`define CFSP_RST_WRAP        9'h092
`define CFSP_RST_MINF        3'h4
`define CFSP_DIV_LAST        5'h0F
`define CFSP_THIRD           16'h5556
`endif

/* hdl/cfsp_pkg.sv */
// types shared by the cube face select and parameter check block
// assumes: cfsp_cfg.svh on the include path
`default_nettype none
package cfsp_pkg;
	typedef enum logic [1:0] {
		CFSP_IDLE = 2'b00,
		CFSP_DIV  = 2'b01,
		CFSP_DONE = 2'b10
	} cfsp_fsm_t;
	typedef enum logic [2:0] {
		CFSP_CLAMP_WRAP        = 3'h0,
		CFSP_EDGE_CLAMP_WRAP   = 3'h1,
		CFSP_REPEAT_WRAP       = 3'h2,
		CFSP_BORDER_CLAMP_WRAP = 3'h3,
		CFSP_MIRROR_WRAP       = 3'h4
	} cfsp_wrap_t;
	typedef enum logic [2:0] {
		CFSP_PX = 3'h0,
		CFSP_NX = 3'h1,
		CFSP_PY = 3'h2,
		CFSP_NY = 3'h3,
		CFSP_PZ = 3'h4,
		CFSP_NZ = 3'h5
	} cfsp_face_t;
	typedef enum logic [1:0] {
		CFSP_DEPTH_LUM   = 2'h0,
		CFSP_DEPTH_RED   = 2'h1,
		CFSP_DEPTH_INT   = 2'h2,
		CFSP_DEPTH_ALPHA = 2'h3
	} cfsp_depth_t;
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} cfsp_apb_req_t;
	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} cfsp_apb_rsp_t;
	typedef struct packed {
		logic signed [15:0] x;
		logic signed [15:0] y;
		logic signed [15:0] z;
	} cfsp_dir_t;
	typedef struct packed {
		cfsp_face_t        face;
		logic signed [16:0] sc;
		logic signed [16:0] tc;
		logic [16:0]       ama;
	} cfsp_sel_t;
	typedef struct packed {
		cfsp_face_t  face;
		logic [16:0] s;
		logic [16:0] t;
		cfsp_face_t  nb_s_hi;
		cfsp_face_t  nb_s_lo;
		cfsp_face_t  nb_t_hi;
		cfsp_face_t  nb_t_lo;
	} cfsp_coord_t;
	typedef struct packed {
		logic        valid;
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] c;
	} cfsp_corner_t;
	typedef struct packed {
		logic [4:0]  eff_base;
		logic [4:0]  eff_max;
		cfsp_depth_t depth;
		logic        seamless;
		cfsp_wrap_t  wrap_s;
		cfsp_wrap_t  wrap_t;
		cfsp_wrap_t  wrap_r;
		logic [2:0]  min_filter;
	} cfsp_param_t;
	typedef struct packed {
		logic [7:0]    ctrl;
		logic [4:0]    levels;
		logic [4:0]    base;
		logic [4:0]    maxlvl;
		logic [8:0]    wrap;
		logic [2:0]    minf;
		logic [1:0]    err;
		cfsp_apb_rsp_t rsp;
		cfsp_fsm_t     fsm;
		logic [4:0]    cnt;
		logic [17:0]   den;
		logic [17:0]   rem_s;
		logic [17:0]   rem_t;
		logic [16:0]   q_s;
		logic [16:0]   q_t;
		logic          in_ready;
		cfsp_coord_t   out;
		logic          out_valid;
		logic          cor_valid;
		logic [31:0]   cor_texel;
		cfsp_param_t   param;
	} cfsp_state_t;
endpackage
`default_nettype wire

/* sim/cfsp_assertions.sv */
// checker for cfsp_top: apb timing, face select, seamless wrap, corner mean
// assumes: bound to cfsp_top, one clock, presetn asynchronous active low
`default_nettype none
module cfsp_checker (
	input wire logic                    pclk,
	input wire logic                    presetn,
	input wire cfsp_pkg::cfsp_apb_req_t apb_req,
	input wire cfsp_pkg::cfsp_apb_rsp_t apb_rsp,
	input wire cfsp_pkg::cfsp_dir_t     frag_dir,
	input wire logic                    frag_valid,
	input wire logic                    frag_ready,
	input wire cfsp_pkg::cfsp_coord_t   cube_out,
	input wire logic                    cube_valid,
	input wire logic                    cube_ready,
	input wire cfsp_pkg::cfsp_corner_t  corner_in,
	input wire logic                    corner_valid,
	input wire logic [31:0]             corner_texel,
	input wire cfsp_pkg::cfsp_param_t   param_out
);
	timeunit 1ns;
	timeprecision 1ps;
	import cfsp_pkg::*;
	cfsp_face_t face_reg;
	// 17 bit magnitudes so the most negative input does not wrap
	function automatic cfsp_face_t face_of(input cfsp_dir_t d);
		logic [16:0] ax;
		logic [16:0] ay;
		logic [16:0] az;
		ax = d.x[15] ? -{1'b1, d.x} : {1'b0, d.x};
		ay = d.y[15] ? -{1'b1, d.y} : {1'b0, d.y};
		az = d.z[15] ? -{1'b1, d.z} : {1'b0, d.z};
		if (az >= ay && az >= ax) return d.z[15] ? CFSP_NZ : CFSP_PZ;
		if (ay >= ax) return d.y[15] ? CFSP_NY : CFSP_PY;
		return d.x[15] ? CFSP_NX : CFSP_PX;
	endfunction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			face_reg <= CFSP_PX;
		end else if (frag_valid && frag_ready) begin
			face_reg <= face_of(frag_dir);
		end
	end
	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_setup_ready: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
		else $error("pready missing in first access cycle");
	a_ready_single: assert property (apb_rsp.pready |=> !apb_rsp.pready)
		else $error("pready longer than one cycle");
	a_unmapped_err: assert property (apb_req.psel && !apb_req.penable && !apb_req.pwrite && apb_req.paddr > 8'h1C
		|=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0) else $error("unmapped read not refused");
	a_seam_nearest: assert property (param_out.seamless && !param_out.min_filter[0] |->
		param_out.wrap_s == CFSP_EDGE_CLAMP_WRAP && param_out.wrap_t == CFSP_EDGE_CLAMP_WRAP
		&& param_out.wrap_r == CFSP_EDGE_CLAMP_WRAP) else $error("seamless nearest wrap wrong");
	a_seam_linear: assert property (param_out.seamless && param_out.min_filter[0] |->
		param_out.wrap_s == CFSP_BORDER_CLAMP_WRAP && param_out.wrap_t == CFSP_BORDER_CLAMP_WRAP
		&& param_out.wrap_r == CFSP_BORDER_CLAMP_WRAP) else $error("seamless linear wrap wrong");
	a_corner_mean: assert property (corner_in.valid && corner_in.a == corner_in.b && corner_in.b == corner_in.c
		|=> corner_valid && corner_texel == $past(corner_in.a)) else $error("corner texel not common value");
	a_corner_quiet: assert property (!corner_in.valid |=> !corner_valid)
		else $error("corner valid without request");
	a_face_early: assert property (frag_valid && frag_ready |=> (!cube_valid && !frag_ready)[*8])
		else $error("fragment output or ready too early");
	a_face_latency: assert property (frag_valid && frag_ready |-> ##[16:18] cube_valid)
		else $error("fragment result late");
	a_face_major: assert property (cube_valid |-> cube_out.face == face_reg)
		else $error("cube face not major axis");
	a_out_hold: assert property (cube_valid && !cube_ready |=> cube_valid && $stable(cube_out))
		else $error("cube output changed while stalled");
	a_unit_range: assert property (cube_valid |-> cube_out.s <= 17'h10000 && cube_out.t <= 17'h10000)
		else $error("face coordinate above one");
endmodule
bind cfsp_top cfsp_checker i_cfsp_checker (
	.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .frag_dir(frag_dir),
	.frag_valid(frag_valid), .frag_ready(frag_ready), .cube_out(cube_out), .cube_valid(cube_valid),
	.cube_ready(cube_ready), .corner_in(corner_in), .corner_valid(corner_valid),
	.corner_texel(corner_texel), .param_out(param_out)
);
`default_nettype wire

/* sim/cfsp_top_bench.sv */
// bench for cfsp_top: register checks, face select, seamless wrap, corner mean
// assumes: checker bound to the design, apb slave answers without wait states
`default_nettype none
module cfsp_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import cfsp_pkg::*;
	typedef struct {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] rd; logic [1:0] er;} cfsp_row_t;
	typedef struct {logic [47:0] d; logic [2:0] f; logic [16:0] s; logic [16:0] t; logic [11:0] n;} cfsp_frow_t;
	logic          pclk;
	logic          presetn;
	cfsp_apb_req_t apb_req;
	cfsp_apb_rsp_t apb_rsp;
	cfsp_dir_t     frag_dir;
	logic          frag_valid;
	logic          frag_ready;
	cfsp_coord_t   cube_out;
	logic          cube_valid;
	logic          cube_ready;
	cfsp_corner_t  corner_in;
	logic          corner_valid;
	logic [31:0]   corner_texel;
	cfsp_param_t   param_out;
	logic [31:0]   rd;
	logic          er;
	int            n_mismatch = 0;
	int            samples_checked = 0;
	// each row: write, read back, then error flags; errors cleared first
	cfsp_row_t rows [21] = '{
		'{8'h00, 32'h14, 8'h00, 32'h14, 2'h0},
		'{8'h10, 32'h49, 8'h10, 32'h49, 2'h0},
		'{8'h10, 32'h4A, 8'h10, 32'h49, 2'h1},
		'{8'h10, 32'h61, 8'h10, 32'h49, 2'h1},
		'{8'h10, 32'h89, 8'h10, 32'h49, 2'h1},
		'{8'h14, 32'h01, 8'h14, 32'h01, 2'h0},
		'{8'h14, 32'h02, 8'h14, 32'h01, 2'h1},
		'{8'h14, 32'h03, 8'h14, 32'h01, 2'h1},
		'{8'h14, 32'h04, 8'h14, 32'h01, 2'h1},
		'{8'h14, 32'h05, 8'h14, 32'h01, 2'h1},
		'{8'h14, 32'h00, 8'h14, 32'h00, 2'h0},
		'{8'h08, 32'h03, 8'h08, 32'h00, 2'h2},
		'{8'h08, 32'h80000000, 8'h08, 32'h00, 2'h2},
		'{8'h00, 32'h12, 8'h1C, 32'h00, 2'h0},
		'{8'h04, 32'h04, 8'h1C, 32'h0300, 2'h0},
		'{8'h08, 32'h09, 8'h1C, 32'h0303, 2'h0},
		'{8'h0C, 32'h02, 8'h1C, 32'h0303, 2'h0},
		'{8'h08, 32'h01, 8'h1C, 32'h0201, 2'h0},
		'{8'h00, 32'h1A, 8'h1C, 32'h10201, 2'h0},
		'{8'h00, 32'hFA, 8'h1C, 32'h30201, 2'h0},
		'{8'h10, 32'hD3, 8'h10, 32'hD3, 2'h0}
	};
	cfsp_frow_t frows [9] = '{
		'{48'h006400000000, 3'h0, 17'h08000, 17'h08000, 12'hB1A},
		'{48'h0040FFE00010, 3'h0, 17'h06000, 17'h0C000, 12'hB1A},
		'{48'hFF9C00320000, 3'h1, 17'h08000, 17'h04000, 12'h95A},
		'{48'h006400640000, 3'h2, 17'h10000, 17'h08000, 12'h065},
		'{48'h0014FF9C0028, 3'h3, 17'h09999, 17'h04CCC, 12'h06C},
		'{48'hFFE2000A0050, 3'h4, 17'h05000, 17'h07000, 12'h05A},
		'{48'h000000000000, 3'h4, 17'h00000, 17'h00000, 12'h05A},
		'{48'h00000064FF9C, 3'h5, 17'h08000, 17'h00000, 12'h21A},
		'{48'h00280000FFC4, 3'h5, 17'h02AAA, 17'h08000, 12'h21A}
	};
	cfsp_corner_t cin [3] = '{'{1'b1, 32'hA1B2C3D4, 32'hA1B2C3D4, 32'hA1B2C3D4},
		'{1'b1, 32'h03, 32'h00, 32'h00}, '{1'b1, 32'h090000FF, 32'h03000000, 32'h00}};
	logic [31:0] cexp [3] = '{32'hA1B2C3D4, 32'h01, 32'h04000055};
	cfsp_top i_cfsp_top (
		.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .frag_dir(frag_dir),
		.frag_valid(frag_valid), .frag_ready(frag_ready), .cube_out(cube_out), .cube_valid(cube_valid),
		.cube_ready(cube_ready), .corner_in(corner_in), .corner_valid(corner_valid),
		.corner_texel(corner_texel), .param_out(param_out)
	);
	always #25 pclk = ~pclk;
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] ex);
		samples_checked++;
		if (got !== ex) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// a bounded wait ran out: count it and stop
	task automatic hang(input string nm);
		n_mismatch++;
		$display("mismatch %s expected 1 seen 0", nm);
		end_sim();
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		@(posedge pclk);
		apb_req <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (apb_rsp.pready !== 1'b1 && n < 16);
		q = apb_rsp.prdata;
		e = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
		if (n >= 16) hang("pready");
	endtask
	task automatic wrap_chk(input logic [31:0] ex, input logic [3:0] mf);
		repeat (2) @(posedge pclk);
		chk("wrap", {23'h0, param_out.wrap_r, param_out.wrap_t, param_out.wrap_s}, ex);
		chk("filter", {28'h0, param_out.min_filter, param_out.seamless}, {28'h0, mf});
	endtask
	task automatic frag(input cfsp_frow_t r);
		int n;
		@(posedge pclk);
		frag_dir <= r.d;
		frag_valid <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (frag_ready !== 1'b1 && n < 40);
		frag_valid <= 1'b0;
		if (n >= 40) hang("frag_ready");
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (cube_valid !== 1'b1 && n < 40);
		if (n >= 40) hang("cube_valid");
		chk("face", {29'h0, cube_out.face}, {29'h0, r.f});
		chk("s", {15'h0, cube_out.s}, {15'h0, r.s});
		chk("t", {15'h0, cube_out.t}, {15'h0, r.t});
		chk("nbr", {20'h0, cube_out.nb_s_hi, cube_out.nb_s_lo, cube_out.nb_t_hi, cube_out.nb_t_lo},
			{20'h0, r.n});
		repeat (3) @(posedge pclk);
		cube_ready <= 1'b1;
		@(posedge pclk);
		cube_ready <= 1'b0;
	endtask
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		apb_req = '0;
		frag_dir = '0;
		frag_valid = 1'b0;
		cube_ready = 1'b0;
		corner_in = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h0C, 32'h0, rd, er);
		chk("maxlvl_reset", rd, 32'h1F);
		apb(1'b0, 8'h10, 32'h0, rd, er);
		chk("wrap_reset", rd, 32'h92);
		apb(1'b0, 8'h00, 32'h0, rd, er);
		chk("ctrl_reset", rd, 32'h0);
		foreach (rows[i]) begin
			apb(1'b1, 8'h18, 32'h3, rd, er);
			apb(1'b1, rows[i].wa, rows[i].wd, rd, er);
			apb(1'b0, rows[i].ra, 32'h0, rd, er);
			chk("reg", rd, rows[i].rd);
			apb(1'b0, 8'h18, 32'h0, rd, er);
			chk("err", rd, {30'h0, rows[i].er});
		end
		$display("test register rows done");
		apb(1'b0, 8'h20, 32'h0, rd, er);
		chk("slverr", {31'h0, er}, 32'h1);
		chk("unmapped", rd, 32'h0);
		wrap_chk(32'hD3, 4'h0);
		apb(1'b1, 8'h00, 32'h1B, rd, er);
		wrap_chk(32'h49, 4'h1);
		apb(1'b1, 8'h14, 32'h1, rd, er);
		wrap_chk(32'hDB, 4'h3);
		apb(1'b1, 8'h00, 32'h1A, rd, er);
		wrap_chk(32'hD3, 4'h2);
		$display("test seamless wrap done");
		foreach (frows[i]) frag(frows[i]);
		$display("test face select done");
		foreach (cin[i]) begin
			@(posedge pclk);
			corner_in <= cin[i];
			@(posedge pclk);
			corner_in.valid <= 1'b0;
			@(posedge pclk);
			chk("corner_valid", {31'h0, corner_valid}, 32'h1);
			chk("corner", corner_texel, cexp[i]);
		end
		$display("test corner done");
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h00, 32'h0, rd, er);
		chk("ctrl_rerun", rd, 32'h0);
		chk("ready_rerun", {31'h0, frag_ready}, 32'h0);
		$display("test second reset done");
		end_sim();
	end
endmodule
`default_nettype wire
